// File: logic/pdt_map.svh
// Purpose: Register offsets, field positions, reset values and counts for the
//          prescaled down-counter timer.
// Assumes: Byte-wide register port with an 8-bit address.
// Notes:   Definitions only.
`ifndef PDT_MAP_SVH
`define PDT_MAP_SVH

// Register offsets
`define PDT_PRESCALE_ADDR   8'hd2
`define PDT_COUNT_ADDR      8'hd3
`define PDT_CONTROL_ADDR    8'hd4
`define PDT_IRQ_STATUS_ADDR 8'hd8
`define PDT_IRQ_MASK_ADDR   8'hd9

// Control/status field positions
`define PDT_CTL_ZERO_BIT    7
`define PDT_CTL_IEN_BIT     6
`define PDT_CTL_DIR_BIT     5
`define PDT_CTL_DOUT_BIT    4
`define PDT_CTL_RUN_BIT     3
`define PDT_CTL_TAP_MSB     2
`define PDT_CTL_TAP_LSB     0

// Interrupt status/mask field positions
`define PDT_IRQ_ZERO_BIT    0
`define PDT_IRQ_EDGE_BIT    1
`define PDT_IRQ_WIDTH       2

// Reset values
`define PDT_COUNT_RESET     8'hff
`define PDT_PRESCALE_RESET  7'h7f
`define PDT_CONTROL_RESET   8'h00
`define PDT_IRQ_RESET       2'h0

// Internal clock divider ahead of the prescaler
`define PDT_CLK_DIV         12

`endif

// File: logic/pdt_pkg.sv
// Purpose: Types shared by the prescaled down-counter timer.
// Assumes: Constants live in pdt_map.svh.
// Notes:   Types only.
package pdt_pkg;

   typedef logic [7:0] pdt_byte_t;
   typedef logic [6:0] pdt_presc_t;
   typedef logic [2:0] pdt_tap_t;

   // Pin operating modes
   typedef enum logic [1:0] {
      PDT_EVENT,
      PDT_GATED,
      PDT_OUTPUT
   } pdt_mode_t;

endpackage

// File: logic/pdt_pin_sync.sv
// Purpose: Bring the timer pin into the core clock and find its rising edges.
// Assumes: Pin may change at any time relative to clk_sys.
// Notes:   First stage feeds only the second stage.
`timescale 1ns/1ps
module pdt_pin_sync (
   input  wire logic clk_sys,
   input  wire logic rst_n,
   input  wire logic pin_async,
   output logic      pin_level,
   output logic      pin_rise
);

   logic meta;
   logic level_d;

   // Two-stage synchroniser, then edge memory
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         meta      <= 1'b0;
         pin_level <= 1'b0;
         level_d   <= 1'b0;
      end else begin
         meta      <= pin_async;
         pin_level <= meta;
         level_d   <= pin_level;
      end
   end

   // Rising edge from settled stages only
   assign pin_rise = pin_level & ~level_d;

endmodule // pdt_pin_sync

// File: logic/pdt_timer.sv
// Purpose: 8-bit down-counter behind a 7-bit prescaler with selectable tap,
//          timer pin as event input, gate input or output, zero flag and irq.
// Assumes: Register port: address, write data, write and read strobes,
//          read data in the cycle after the read strobe.
// Notes:   Internal tick is clk_sys divided by CLK_DIV.
`timescale 1ns/1ps
`include "pdt_map.svh"

// What this block does
// - Zero flag on decrement, zero write, bit7
// - Reset: count FF, prescaler 7F, control clear
// - Output latch follows data while flag high in output mode
// - Counter write beats decrement-to-zero flag
// - Counter and prescaler read live values
// - Timer irq when flag and enable set
// - Bit 5 selects pin input or output
// - Bit 4 output level or input mode
// - Run bit low forces 7F, halts counter and prescaler
// - Tap code n divides by two^n
// - Counter decrements on rising tap edge
// - Prescaler fed by tick or pin
// - Gated counts while high; event counts edges
// - Prescaler loadable while running
module pdt_timer #(
   parameter int unsigned CLK_DIV = `PDT_CLK_DIV
) (
   input  wire logic             clk_sys,
   input  wire logic             rst_n,
   input  wire pdt_pkg::pdt_byte_t reg_addr,
   input  wire pdt_pkg::pdt_byte_t reg_wdata,
   input  wire logic             reg_wr,
   input  wire logic             reg_rd,
   output pdt_pkg::pdt_byte_t    reg_rdata,
   input  wire logic             timer_pin_in,
   output logic                  timer_pin_out,
   output logic                  timer_pin_oe,
   output logic                  timer_irq,
   output logic                  event_irq
);
   import pdt_pkg::*;

   // Divider width; a divide of one still needs one bit so the
   // compare below stays legal
   localparam int unsigned DW = (CLK_DIV > 1) ? $clog2(CLK_DIV) : 1;
   localparam logic [DW-1:0] DIV_LAST = DW'(CLK_DIV - 1);

   // Register state
   // Control bits kept as named flops, assembled only for readback
   pdt_byte_t                   count_value;
   pdt_presc_t                  prescale_value;
   logic                        count_zero_flag;
   logic                        zero_irq_enable;
   logic                        pin_direction_select;
   logic                        dout_mode;
   logic                        prescaler_run;
   pdt_tap_t                    tap_select;
   logic [`PDT_IRQ_WIDTH-1:0]   irq_status;
   logic [`PDT_IRQ_WIDTH-1:0]   irq_mask;
   logic [DW-1:0]               div_cnt;

   // Combinational nets
   logic                        pin_level;
   logic                        pin_rise;
   pdt_mode_t                   pin_mode;
   logic                        div_tick;
   logic                        presc_tick;
   logic                        count_tick;
   pdt_presc_t                  next_presc;
   logic                        tap_old;
   logic                        tap_new;
   logic                        hit_zero;
   logic                        zero_set;
   logic                        zero_clr;
   logic                        next_zero;
   logic [`PDT_IRQ_WIDTH-1:0]   irq_events;
   logic [`PDT_IRQ_WIDTH-1:0]   irq_clear;
   logic [`PDT_IRQ_WIDTH-1:0]   next_irq_status;
   pdt_byte_t                   control_read;
   pdt_byte_t                   next_rdata;
   logic                        wr_count;
   logic                        wr_presc;
   logic                        wr_ctl;
   logic                        wr_istat;
   logic                        wr_imask;

   // Selected tap bit of a prescaler value; code 0 has no bit
   // Code 0 is handled by the caller, which counts every tick
   function automatic logic tap_out(input pdt_presc_t p, input pdt_tap_t s);
      pdt_tap_t idx;
      idx = s - 3'd1;
      tap_out = (s == 3'd0) ? 1'b0 : p[idx];
   endfunction

   // Pin moves freely from outside, so it never feeds logic raw
   // pin sync and edges
   pdt_pin_sync u_pin_sync (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .pin_async (timer_pin_in),
      .pin_level (pin_level),
      .pin_rise  (pin_rise)
   );

   // Address decode
   // Unmapped writes match nothing and are dropped
   assign wr_count = reg_wr && (reg_addr == `PDT_COUNT_ADDR);
   assign wr_presc = reg_wr && (reg_addr == `PDT_PRESCALE_ADDR);
   assign wr_ctl   = reg_wr && (reg_addr == `PDT_CONTROL_ADDR);
   assign wr_istat = reg_wr && (reg_addr == `PDT_IRQ_STATUS_ADDR);
   assign wr_imask = reg_wr && (reg_addr == `PDT_IRQ_MASK_ADDR);

   // data bit picks gated or event
   assign pin_mode = pin_direction_select ? PDT_OUTPUT :
                     (dout_mode ? PDT_GATED : PDT_EVENT);

   // Internal divide-by-CLK_DIV tick
   // Wrap at CLK_DIV-1 gives one tick every CLK_DIV clocks
   // Free-runs from reset; tick phase is not software visible
   assign div_tick = (div_cnt == DIV_LAST);

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         div_cnt <= '0;
      end else if (div_tick) begin
         div_cnt <= '0;
      end else begin
         div_cnt <= div_cnt + DW'(1);
      end
   end

   // Gate and event inputs use the synchronised pin only
   // prescaler input select
   always_comb begin
      case (pin_mode)
         PDT_EVENT:  presc_tick = pin_rise;
         PDT_GATED:  presc_tick = div_tick & pin_level;
         PDT_OUTPUT: presc_tick = div_tick;
         default:    presc_tick = 1'b0;
      endcase
   end

   // Down-count wraps from 00 to 7F
   assign next_presc = prescale_value - 7'h01;

   assign tap_old = tap_out(prescale_value, tap_select);
   assign tap_new = tap_out(next_presc, tap_select);

   // Old and new tap bit compared, no extra flop per tap
   // Prescaler counts down, so a tap bit rises on a borrow
   // decrement on tap rise
   assign count_tick = prescaler_run && presc_tick &&
                       ((tap_select == 3'd0) || (!tap_old && tap_new));

   // Counter at 01 plus a tick is the decrement that lands on 00
   // write masks the zero event
   assign hit_zero = count_tick && (count_value == 8'h01) && !wr_count;

   assign zero_set = hit_zero ||
                     (wr_count && (reg_wdata == 8'h00)) ||
                     (wr_ctl && reg_wdata[`PDT_CTL_ZERO_BIT]);

   assign zero_clr  = wr_ctl && !reg_wdata[`PDT_CTL_ZERO_BIT];
   // Set beats clear so no zero is lost
   assign next_zero = zero_set || (count_zero_flag && !zero_clr);

   // Counter register
   // Software write beats the tick; that tick is lost
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         count_value <= `PDT_COUNT_RESET;
      end else if (wr_count) begin
         count_value <= reg_wdata;
      end else if (count_tick) begin
         count_value <= count_value - 8'h01;
      end
   end

   // Prescaler register
   // Run low wins over a load, so a stopped prescaler shows 7F
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         prescale_value <= `PDT_PRESCALE_RESET;
      end else if (!prescaler_run) begin
         prescale_value <= `PDT_PRESCALE_RESET;
      end else if (wr_presc) begin
         prescale_value <= reg_wdata[6:0];
      end else if (presc_tick) begin
         prescale_value <= next_presc;
      end
   end

   // Control/status register
   // Flag updates every cycle; other fields only on a control write
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         count_zero_flag      <= 1'b0;
         zero_irq_enable      <= 1'b0;
         pin_direction_select <= 1'b0;
         dout_mode            <= 1'b0;
         prescaler_run        <= 1'b0;
         tap_select           <= 3'd0;
      end else begin
         count_zero_flag <= next_zero;
         if (wr_ctl) begin
            zero_irq_enable      <= reg_wdata[`PDT_CTL_IEN_BIT];
            pin_direction_select <= reg_wdata[`PDT_CTL_DIR_BIT];
            dout_mode            <= reg_wdata[`PDT_CTL_DOUT_BIT];
            prescaler_run        <= reg_wdata[`PDT_CTL_RUN_BIT];
            tap_select           <= reg_wdata[`PDT_CTL_TAP_MSB:`PDT_CTL_TAP_LSB];
         end
      end
   end

   // Pin driver; latch holds once the flag drops
   // Registered, so the pin moves one clock after the flag
   // Flag low keeps the last driven level rather than clearing it
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         timer_pin_out <= 1'b0;
         timer_pin_oe  <= 1'b0;
      end else begin
         timer_pin_oe <= pin_direction_select;
         if (pin_direction_select && count_zero_flag) begin
            timer_pin_out <= dout_mode;
         end
      end
   end

   // Level request; stays up until software drops flag or enable
   // timer request from flag and enable
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         timer_irq <= 1'b0;
      end else begin
         timer_irq <= count_zero_flag && zero_irq_enable;
      end
   end

   // Sticky event bits, write one to clear, set wins
   // Counter bit only from real decrements, not software writes
   assign irq_events      = {pin_rise, hit_zero};
   assign irq_clear       = wr_istat ? reg_wdata[`PDT_IRQ_WIDTH-1:0] : '0;
   assign next_irq_status = irq_events | (irq_status & ~irq_clear);

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         irq_status <= `PDT_IRQ_RESET;
         irq_mask   <= `PDT_IRQ_RESET;
         event_irq  <= 1'b0;
      end else begin
         irq_status <= next_irq_status;
         if (wr_imask) begin
            irq_mask <= reg_wdata[`PDT_IRQ_WIDTH-1:0];
         end
         event_irq <= |(irq_status & irq_mask);
      end
   end

   // Readback assembly
   // Unmapped addresses return 00, so a stray read is harmless
   assign control_read = {count_zero_flag, zero_irq_enable, pin_direction_select,
                          dout_mode, prescaler_run, tap_select};

   always_comb begin
      case (reg_addr)
         `PDT_PRESCALE_ADDR:   next_rdata = {1'b0, prescale_value};
         `PDT_COUNT_ADDR:      next_rdata = count_value;
         `PDT_CONTROL_ADDR:    next_rdata = control_read;
         `PDT_IRQ_STATUS_ADDR: next_rdata = {6'h00, irq_status};
         `PDT_IRQ_MASK_ADDR:   next_rdata = {6'h00, irq_mask};
         default:              next_rdata = 8'h00;
      endcase
   end

   // Read data stands one cycle after the strobe only
   // Back to 00 outside the read slot keeps a shared bus quiet
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= next_rdata;
      end else begin
         reg_rdata <= 8'h00;
      end
   end

endmodule // pdt_timer

// File: verification/pdt_timer_monitor.sv
// Purpose: Port-level checks for the down-counter timer.
// Assumes: Sees only the pdt_timer ports.
// Notes:   Bound from the test top.
`timescale 1ns/1ps
module pdt_timer_monitor (
   input wire logic               clk_sys,
   input wire logic               rst_n,
   input wire pdt_pkg::pdt_byte_t reg_addr,
   input wire pdt_pkg::pdt_byte_t reg_wdata,
   input wire logic               reg_wr,
   input wire logic               reg_rd,
   input wire pdt_pkg::pdt_byte_t reg_rdata,
   input wire logic               timer_pin_in,
   input wire logic               timer_pin_out,
   input wire logic               timer_pin_oe,
   input wire logic               timer_irq,
   input wire logic               event_irq
);
   import pdt_pkg::*;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // Control and counter write decodes
   wire ctl_wr = reg_wr && reg_addr == 8'hd4;
   wire cnt_wr = reg_wr && reg_addr == 8'hd3;

   property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
   property p_psc_b7; $past(reg_rd) && $past(reg_addr) == 8'hd2 |-> !reg_rdata[7]; endproperty
   a_psc_b7: assert property (p_psc_b7) else $error("prescale bit 7 set");
   property p_irq_off; ctl_wr && !reg_wdata[6] ##1 !reg_wr |=> !timer_irq; endproperty
   a_irq_off: assert property (p_irq_off) else $error("irq while disabled");
   property p_irq_on; ctl_wr && reg_wdata[7:6] == 2'b11 ##1 !reg_wr |=> timer_irq; endproperty
   a_irq_on: assert property (p_irq_on) else $error("irq missing");
   property p_oe; ctl_wr |=> ##1 timer_pin_oe == $past(reg_wdata[5], 2); endproperty
   a_oe: assert property (p_oe) else $error("pin direction wrong");
   property p_out_hold; $changed(timer_pin_out) |-> timer_pin_oe; endproperty
   a_out_hold: assert property (p_out_hold) else $error("pin moved in input mode");
   property p_out_follow;
      ctl_wr && reg_wdata[7] && reg_wdata[5] ##1 !reg_wr
         |=> timer_pin_out == $past(reg_wdata[4], 2);
   endproperty
   a_out_follow: assert property (p_out_follow) else $error("pin not data out");
   property p_zero_wr;
      cnt_wr && reg_wdata == 8'h00 ##1 !reg_wr ##1 (reg_rd && reg_addr == 8'hd4)
         |=> reg_rdata[7];
   endproperty
   a_zero_wr: assert property (p_zero_wr) else $error("zero write left flag low");
endmodule // pdt_timer_monitor

// File: verification/pdt_pin_source.sv
// Purpose: Outside source on the timer pin: edges and gate levels.
// Assumes: Bench resolves the line while the timer drives it.
// Notes:   Rising edges seven clocks apart so none is merged.
`timescale 1ns/1ps
module pdt_pin_source (
   input wire logic clk_sys,
   output logic     level
);
   initial level = 1'b0;
   // Rising edges, three clocks high and four low
   task automatic pulses(input int n);
      repeat (n) begin
         @(posedge clk_sys) level <= 1'b1;
         repeat (3) @(posedge clk_sys);
         level <= 1'b0;
         repeat (3) @(posedge clk_sys);
      end
   endtask
   // Steady gate level
   task automatic gate(input logic v);
      @(posedge clk_sys) level <= v;
   endtask
endmodule // pdt_pin_source

// File: verification/pdt_timer_test.sv
// Purpose: Self-checking bench for the down-counter timer.
// Assumes: Tick divider shortened to 3.
// Notes:   Pulse counts random from a fixed seed.
`timescale 1ns/1ps
module pdt_timer_test;
   import pdt_pkg::*;
   logic      clk_sys, rst_n, reg_wr, reg_rd, src_level;
   logic      timer_pin_out, timer_pin_oe, timer_irq, event_irq;
   pdt_byte_t reg_addr, reg_wdata, reg_rdata, d, r;
   int        err_total, check_count, n;
   // Timer drives the line when enabled, else the source does
   wire       timer_pin_in = timer_pin_oe ? timer_pin_out : src_level;

   pdt_timer #(.CLK_DIV(3)) u_pdt_timer (.clk_sys(clk_sys), .rst_n(rst_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .timer_pin_in(timer_pin_in), .timer_pin_out(timer_pin_out),
      .timer_pin_oe(timer_pin_oe), .timer_irq(timer_irq), .event_irq(event_irq));
   pdt_pin_source u_pdt_pin_source (.clk_sys(clk_sys), .level(src_level));

   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   task automatic wr(input pdt_byte_t a, v);
      @(posedge clk_sys);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= v;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   // Read data stands only in the cycle after the strobe
   task automatic rd(input pdt_byte_t a);
      @(posedge clk_sys);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic chk(input string s, input pdt_byte_t seen, exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", s, exp, seen);
      end
   endtask
   task automatic rchk(input string s, input pdt_byte_t a, exp);
      rd(a);
      chk(s, d, exp);
   endtask
   // Control write, then let registered outputs settle
   task automatic ctl(input pdt_byte_t v);
      wr(8'hd4, v);
      repeat (2) @(posedge clk_sys);
      #1;
   endtask
   // Counter steps: tap 0 every edge, else tap bit rising as prescaler counts down
   function automatic int exp_dec(input int k, input int n);
      int         c = 0;
      pdt_presc_t p = 7'h7f;
      pdt_presc_t q;
      for (int i = 0; i < n; i++) begin
         q = p - 7'h01;
         if (k == 0 || (!p[k-1] && q[k-1])) c++;
         p = q;
      end
      return c;
   endfunction
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Hang guard, well beyond the longest scenario
   initial begin
      repeat (30000) @(posedge clk_sys);
      err_total++;
      end_of_test();
   end

   initial begin
      void'($urandom(25));
      {err_total, check_count} = '0;
      {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      repeat (20) @(posedge clk_sys);
      rst_n <= 1'b1;
      // Reset contents and a hole in the map
      rchk("prescale", 8'hd2, 8'h7f);
      rchk("count", 8'hd3, 8'hff);
      rchk("control", 8'hd4, 8'h00);
      rchk("unmapped", 8'h00, 8'h00);
      wr(8'hd2, 8'h12);
      rchk("prescale", 8'hd2, 8'h7f);
      // Every tap in event mode, live reads after
      for (int k = 0; k < 8; k++) begin
         n = 120 + $urandom % 20;
         wr(8'hd4, 8'h00);
         wr(8'hd3, 8'hff);
         wr(8'hd4, 8'h08 | 8'(k));
         u_pdt_pin_source.pulses(n);
         repeat (6) @(posedge clk_sys);
         rchk("count", 8'hd3, 8'(255 - exp_dec(k, n)));
         rchk("prescale", 8'hd2, 8'((127 - n) & 127));
      end
      // Load prescaler while running
      r = 8'($urandom % 128);
      wr(8'hd2, r);
      rchk("prescale", 8'hd2, r);
      // Count down to zero with interrupts
      ctl(8'h00);
      wr(8'hd3, 8'h02);
      wr(8'hd9, 8'h01);
      ctl(8'h08);
      u_pdt_pin_source.pulses(2);
      repeat (6) @(posedge clk_sys);
      rchk("control", 8'hd4, 8'h88);
      chk("irq_off", {7'h00, timer_irq}, 8'h00);
      chk("event_irq", {7'h00, event_irq}, 8'h01);
      ctl(8'hc8);
      chk("irq_on", {7'h00, timer_irq}, 8'h01);
      ctl(8'h48);
      wr(8'hd8, 8'h03);
      repeat (2) @(posedge clk_sys);
      #1;
      chk("irq_clr", {6'h00, timer_irq, event_irq}, 8'h00);
      wr(8'hd3, 8'h00);
      rchk("control", 8'hd4, 8'hc8);
      // Counter write on the decrement to 00 wins, flag stays low
      wr(8'hd3, 8'h01);
      ctl(8'h48);
      fork
         u_pdt_pin_source.pulses(1);
         begin
            repeat (2) @(posedge clk_sys);
            wr(8'hd3, 8'h55);
         end
      join
      repeat (6) @(posedge clk_sys);
      rchk("count", 8'hd3, 8'h55);
      rchk("control", 8'hd4, 8'h48);
      // Output mode: follows data while flag high, then holds
      ctl(8'hb0);
      chk("pin", {6'h00, timer_pin_oe, timer_pin_out}, 8'h03);
      ctl(8'h20);
      chk("pin", {6'h00, timer_pin_oe, timer_pin_out}, 8'h03);
      ctl(8'ha0);
      chk("pin", {6'h00, timer_pin_oe, timer_pin_out}, 8'h02);
      ctl(8'h00);
      chk("pin", {6'h00, timer_pin_oe, timer_pin_out}, 8'h00);
      // Output mode running: decrement to 00 drives the data bit out
      wr(8'hd3, 8'h02);
      ctl(8'h38);
      repeat (10) @(posedge clk_sys);
      #1;
      chk("pin_run", {6'h00, timer_pin_oe, timer_pin_out}, 8'h03);
      rchk("control", 8'hd4, 8'hb8);
      // Stopped: pin edges move neither counter nor prescaler
      ctl(8'h00);
      rd(8'hd3);
      r = d;
      u_pdt_pin_source.pulses(2);
      repeat (6) @(posedge clk_sys);
      rchk("halted", 8'hd3, r);
      rchk("prescale", 8'hd2, 8'h7f);
      // Gated mode counts ticks only while the pin is high
      wr(8'hd3, 8'hff);
      ctl(8'h18);
      repeat (30) @(posedge clk_sys);
      rchk("gate_low", 8'hd3, 8'hff);
      u_pdt_pin_source.gate(1'b1);
      repeat (30) @(posedge clk_sys);
      u_pdt_pin_source.gate(1'b0);
      repeat (6) @(posedge clk_sys);
      rd(8'hd3);
      chk("gate_high", {7'h00, d inside {[8'hf3:8'hf7]}}, 8'h01);
      end_of_test();
   end
endmodule // pdt_timer_test

bind pdt_timer pdt_timer_monitor u_pdt_timer_monitor (.clk_sys(clk_sys), .rst_n(rst_n),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .timer_pin_in(timer_pin_in), .timer_pin_out(timer_pin_out),
   .timer_pin_oe(timer_pin_oe), .timer_irq(timer_irq), .event_irq(event_irq));
